//--- rtl/ptpmc_port.sv
`timescale 1ns/1ps
// Functional notes
// - Ethernet frames use and match Ethertype 0x88f7
// - Peer-delay Ethernet messages to peer multicast MAC
// - Other Ethernet messages to general multicast MAC
// - UDP event port 319, general port 320
// - IPv4 peer group vs general group address
// - Master sends Sync periodically
// - One-step Sync carries own departure time
// - Two-step Follow_Up carries prior Sync time
// - Master answers Delay_Req with Delay_Resp, in unicast only once granted
// - Transparent clock adds residence into correction
// - End-to-end TC corrects every event message
// - Peer TC corrects Sync, Follow_Up only
// - Unicast silent until a remote is configured
// - Unicast sync starts only after grant
// - Unicast profile only over UDP, Signalling
// - Secondary port counts only, never transmits
// - Separate receive counter per message type
// - Slave reports offset from estimated master
// - Master sends Announce periodically
// - Only primary port emulates master or slave
module ptpmc_port
  import ptpmc_pkg::*;
#(
  parameter int SYNC_PERIOD = PTPMC_SYNC_PERIOD,
  parameter int ANN_PERIOD = PTPMC_ANN_PERIOD
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_primary,
  input wire logic i_master,
  input wire logic i_enable,
  input wire logic i_one_step,
  input wire logic i_udp,
  input wire logic i_unicast,
  input wire logic i_remote_valid,
  input wire logic [31:0] i_remote_ip,
  input wire logic [63:0] i_now,
  input wire logic [3:0] i_cnt_sel,
  ptpmc_link_if.dev link,
  output logic [PTPMC_CNT_W-1:0] o_count,
  output logic o_granted,
  output logic signed [63:0] o_offset,
  output logic o_offset_valid
);
  localparam int CW = PTPMC_CNT_W;
  logic [CW-1:0] cnt_q [PTPMC_NTYPES];
  logic [31:0] sync_tmr_q;
  logic [31:0] ann_tmr_q;
  logic fup_pend_q, ann_pend_q;
  logic [63:0] sync_ts_q;
  logic dresp_pend_q;
  logic [63:0] dreq_rx_ts_q;
  logic granted_q;
  logic [63:0] t1_q, t2_q, t3_q;
  logic have_t12_q;
  logic dv_q, udp_o_q;
  logic [3:0] type_q;
  logic [47:0] mac_q;
  logic [15:0] etype_q, port_q;
  logic [31:0] ip_q;
  logic [63:0] ts_q;
  logic [CW-1:0] count_q;
  logic signed [63:0] offset_q;
  logic ovalid_q;

  wire rx_ptp = link.dv_to_dev &
    (link.udp_to_dev ? (link.port_to_dev == PTPMC_UDP_EVENT ||
                        link.port_to_dev == PTPMC_UDP_GENERAL)
                     : (link.etype_to_dev == PTPMC_ETHERTYPE));
  wire [3:0] rt = link.type_to_dev;
  wire emul = i_primary & i_enable;
  wire uni_ok = ~i_unicast | (i_remote_valid & i_udp);
  wire can_tx = emul & uni_ok;
  wire sync_go = can_tx & i_master & (~i_unicast | granted_q) &
    (sync_tmr_q == 32'(SYNC_PERIOD - 1));
  wire ann_due = can_tx & i_master &
    (ann_tmr_q == 32'(ANN_PERIOD - 1));
  wire uni_master_ok = ~i_unicast | granted_q;

  // Priority: Follow_Up, Delay_Resp, Sync, Announce, Signalling, Delay_Req
  logic tx_go;
  logic [3:0] tx_type;
  logic [63:0] tx_ts;
  wire sig_go = can_tx & ~i_master & i_unicast & ~granted_q &
    (ann_tmr_q == 32'h0000_0000);
  wire dreq_go = can_tx & ~i_master & uni_master_ok & have_t12_q &
    (sync_tmr_q == 32'(SYNC_PERIOD / 2));
  always_comb begin
    tx_go = 1'b1;
    tx_type = PTPMC_SYNC;
    tx_ts = i_now;
    if (fup_pend_q) begin
      tx_type = PTPMC_FUP;
      tx_ts = sync_ts_q;
    end else if (dresp_pend_q) begin
      tx_type = PTPMC_DRESP;
      tx_ts = dreq_rx_ts_q;
    end else if (sync_go) begin
      tx_type = PTPMC_SYNC;
      // Two-step keeps the issue time too, so Follow_Up pairs by value
      tx_ts = i_now;
    end else if (ann_pend_q) begin
      tx_type = PTPMC_ANNOUNCE;
    end else if (sig_go) begin
      tx_type = PTPMC_SIGNAL;
    end else if (dreq_go) begin
      tx_type = PTPMC_DREQ;
    end else begin
      tx_go = 1'b0;
    end
  end
  wire tx_pd = (tx_type == PTPMC_PDREQ) | (tx_type == PTPMC_PDRESP) |
    (tx_type == PTPMC_PDFUP);
  wire tx_event = ~tx_type[3];
  wire [47:0] tx_mac = tx_pd ? PTPMC_MAC_PDELAY : PTPMC_MAC_GENERAL;
  wire [31:0] tx_ip = i_unicast ? i_remote_ip :
    (tx_pd ? PTPMC_IP_PDELAY : PTPMC_IP_GENERAL);
  wire [15:0] tx_port = tx_event ? PTPMC_UDP_EVENT : PTPMC_UDP_GENERAL;

  wire rx_mine = rx_ptp & emul;
  wire rx_dreq = rx_mine & i_master & (rt == PTPMC_DREQ) & uni_master_ok;
  wire rx_sync = rx_mine & ~i_master & (rt == PTPMC_SYNC);
  wire rx_fup = rx_mine & ~i_master & (rt == PTPMC_FUP);
  wire rx_dresp = rx_mine & ~i_master & (rt == PTPMC_DRESP);
  wire rx_grant = rx_mine & ~i_master & (rt == PTPMC_SIGNAL) & i_unicast;
  wire signed [63:0] off_calc = ($signed(t2_q - t1_q) -
    $signed(link.ts_to_dev - t3_q)) >>> 1;

  genvar g;
  generate
    for (g = 0; g < PTPMC_NTYPES; g++) begin : g_cnt
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          cnt_q[g] <= '0;
        end else if (rx_ptp && rt == 4'(g)) begin
          cnt_q[g] <= cnt_q[g] + 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst || !can_tx || sync_tmr_q == 32'(SYNC_PERIOD - 1)) begin
      sync_tmr_q <= '0;
    end else begin
      sync_tmr_q <= sync_tmr_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !can_tx || ann_tmr_q == 32'(ANN_PERIOD - 1)) begin
      ann_tmr_q <= '0;
    end else begin
      ann_tmr_q <= ann_tmr_q + 1'b1;
    end
  end

  // New requests set the pending flags ahead of the clear by transmission
  always_ff @(posedge i_clk) begin
    if (i_srst || !can_tx) begin
      fup_pend_q <= 1'b0;
      ann_pend_q <= 1'b0;
      dresp_pend_q <= 1'b0;
      sync_ts_q <= '0;
      dreq_rx_ts_q <= '0;
    end else begin
      if (tx_go && tx_type == PTPMC_SYNC && !i_one_step) begin
        fup_pend_q <= 1'b1;
        sync_ts_q <= i_now;
      end else if (fup_pend_q) begin
        fup_pend_q <= 1'b0;
      end
      if (rx_dreq) begin
        dresp_pend_q <= 1'b1;
        dreq_rx_ts_q <= i_now;
      end else if (tx_go && tx_type == PTPMC_DRESP) begin
        dresp_pend_q <= 1'b0;
      end
      // Announce due on a Sync edge waits instead of being lost
      if (ann_due) begin
        ann_pend_q <= 1'b1;
      end else if (tx_go && tx_type == PTPMC_ANNOUNCE) begin
        ann_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !i_unicast || !emul) begin
      granted_q <= 1'b0;
    end else if (rx_grant) begin
      granted_q <= 1'b1;
    end
  end

  // Slave: t1 from one-step Sync or Follow_Up, t2 at Sync arrival
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      t1_q <= '0;
      t2_q <= '0;
      t3_q <= '0;
      have_t12_q <= 1'b0;
      offset_q <= '0;
      ovalid_q <= 1'b0;
    end else begin
      ovalid_q <= 1'b0;
      if (rx_sync) begin
        t2_q <= i_now;
        t1_q <= link.ts_to_dev;
        have_t12_q <= 1'b1;
      end
      if (rx_fup) begin
        t1_q <= link.ts_to_dev;
      end
      if (tx_go && tx_type == PTPMC_DREQ) begin
        t3_q <= i_now;
      end
      if (rx_dresp) begin
        offset_q <= off_calc;
        ovalid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dv_q <= 1'b0;
      type_q <= '0;
      udp_o_q <= 1'b0;
      mac_q <= '0;
      etype_q <= '0;
      ip_q <= '0;
      port_q <= '0;
      ts_q <= '0;
      count_q <= '0;
    end else begin
      dv_q <= tx_go;
      type_q <= tx_type;
      udp_o_q <= i_udp;
      mac_q <= tx_mac;
      etype_q <= PTPMC_ETHERTYPE;
      ip_q <= tx_ip;
      port_q <= tx_port;
      ts_q <= tx_ts;
      count_q <= cnt_q[i_cnt_sel];
    end
  end

  assign link.dv_from_dev = dv_q;
  assign link.type_from_dev = type_q;
  assign link.udp_from_dev = udp_o_q;
  assign link.mac_from_dev = mac_q;
  assign link.etype_from_dev = etype_q;
  assign link.ip_from_dev = ip_q;
  assign link.port_from_dev = port_q;
  assign link.ts_from_dev = ts_q;
  assign link.corr_from_dev = PTPMC_CORR_ZERO;
  assign o_count = count_q;
  assign o_granted = granted_q;
  assign o_offset = offset_q;
  assign o_offset_valid = ovalid_q;
endmodule : ptpmc_port

//--- rtl/ptpmc_pkg.sv
package ptpmc_pkg;
  localparam logic [15:0] PTPMC_ETHERTYPE = 16'h88f7;
  localparam logic [47:0] PTPMC_MAC_PDELAY = 48'h011b_1900_0000;
  localparam logic [47:0] PTPMC_MAC_GENERAL = 48'h0180_c200_000e;
  localparam logic [15:0] PTPMC_UDP_EVENT = 16'h013f;
  localparam logic [15:0] PTPMC_UDP_GENERAL = 16'h0140;
  localparam logic [31:0] PTPMC_IP_PDELAY = 32'he000_006b;
  localparam logic [31:0] PTPMC_IP_GENERAL = 32'he000_0181;
  localparam int PTPMC_NTYPES = 16;
  localparam logic [3:0] PTPMC_SYNC = 4'h0;
  localparam logic [3:0] PTPMC_DREQ = 4'h1;
  localparam logic [3:0] PTPMC_PDREQ = 4'h2;
  localparam logic [3:0] PTPMC_PDRESP = 4'h3;
  localparam logic [3:0] PTPMC_FUP = 4'h8;
  localparam logic [3:0] PTPMC_DRESP = 4'h9;
  localparam logic [3:0] PTPMC_PDFUP = 4'ha;
  localparam logic [3:0] PTPMC_ANNOUNCE = 4'hb;
  localparam logic [3:0] PTPMC_SIGNAL = 4'hc;
  localparam int PTPMC_CNT_W = 32;
  localparam int PTPMC_TS_W = 64;
  localparam int PTPMC_SYNC_PERIOD = 32'h0000_4e20;
  localparam int PTPMC_ANN_PERIOD = 32'h0000_9c40;
  localparam logic [63:0] PTPMC_CORR_ZERO = 64'h0000_0000_0000_0000;
endpackage : ptpmc_pkg

//--- rtl/ptpmc_link_if.sv
`timescale 1ns/1ps
// One message per cycle in each direction, already parsed into header fields
interface ptpmc_link_if;
  import ptpmc_pkg::*;
  logic dv_to_dev;
  logic [3:0] type_to_dev;
  logic udp_to_dev;
  logic [47:0] mac_to_dev;
  logic [15:0] etype_to_dev;
  logic [31:0] ip_to_dev;
  logic [15:0] port_to_dev;
  logic [63:0] ts_to_dev;
  logic [63:0] corr_to_dev;
  logic dv_from_dev;
  logic [3:0] type_from_dev;
  logic udp_from_dev;
  logic [47:0] mac_from_dev;
  logic [15:0] etype_from_dev;
  logic [31:0] ip_from_dev;
  logic [15:0] port_from_dev;
  logic [63:0] ts_from_dev;
  logic [63:0] corr_from_dev;
  modport dev (
    input dv_to_dev, type_to_dev, udp_to_dev, mac_to_dev, etype_to_dev,
    input ip_to_dev, port_to_dev, ts_to_dev, corr_to_dev,
    output dv_from_dev, type_from_dev, udp_from_dev, mac_from_dev,
    output etype_from_dev, ip_from_dev, port_from_dev, ts_from_dev,
    output corr_from_dev
  );
  modport peer (
    output dv_to_dev, type_to_dev, udp_to_dev, mac_to_dev, etype_to_dev,
    output ip_to_dev, port_to_dev, ts_to_dev, corr_to_dev,
    input dv_from_dev, type_from_dev, udp_from_dev, mac_from_dev,
    input etype_from_dev, ip_from_dev, port_from_dev, ts_from_dev,
    input corr_from_dev
  );
endinterface : ptpmc_link_if

//--- rtl/ptpmc_peer.sv
`timescale 1ns/1ps
// Far entity: transparent clock forwarding user messages, or plain endpoint
module ptpmc_peer
  import ptpmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tc_en,
  input wire logic i_p2p,
  input wire logic i_fwd_valid,
  input wire logic [3:0] i_fwd_type,
  input wire logic i_fwd_udp,
  input wire logic [63:0] i_fwd_ts,
  input wire logic [63:0] i_fwd_corr,
  input wire logic [63:0] i_residence,
  ptpmc_link_if.peer link,
  output logic o_rx_valid,
  output logic [3:0] o_rx_type,
  output logic [63:0] o_rx_ts
);
  logic dv_q, udp_q, rxv_q;
  logic [3:0] type_q, rxt_q;
  logic [47:0] mac_q;
  logic [31:0] ip_q;
  logic [15:0] port_q;
  logic [63:0] ts_q, corr_q, rxts_q;

  wire is_pd = (i_fwd_type == PTPMC_PDREQ) | (i_fwd_type == PTPMC_PDRESP) |
    (i_fwd_type == PTPMC_PDFUP);
  wire is_event = ~i_fwd_type[3];
  wire p2p_fix = (i_fwd_type == PTPMC_SYNC) | (i_fwd_type == PTPMC_FUP);
  wire do_corr = i_tc_en & (i_p2p ? p2p_fix : is_event);
  wire drop = i_tc_en & i_p2p & (i_fwd_type == PTPMC_PDREQ |
    i_fwd_type == PTPMC_PDRESP);
  wire send = i_fwd_valid & ~drop;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dv_q <= 1'b0;
      udp_q <= 1'b0;
      type_q <= '0;
      mac_q <= '0;
      ip_q <= '0;
      port_q <= '0;
      ts_q <= '0;
      corr_q <= '0;
      rxv_q <= 1'b0;
      rxt_q <= '0;
      rxts_q <= '0;
    end else begin
      dv_q <= send;
      udp_q <= i_fwd_udp;
      type_q <= i_fwd_type;
      mac_q <= is_pd ? PTPMC_MAC_PDELAY : PTPMC_MAC_GENERAL;
      ip_q <= is_pd ? PTPMC_IP_PDELAY : PTPMC_IP_GENERAL;
      port_q <= is_event ? PTPMC_UDP_EVENT : PTPMC_UDP_GENERAL;
      ts_q <= i_fwd_ts;
      corr_q <= do_corr ? i_fwd_corr + i_residence : i_fwd_corr;
      rxv_q <= link.dv_from_dev &
        (link.udp_from_dev | link.etype_from_dev == PTPMC_ETHERTYPE);
      rxt_q <= link.type_from_dev;
      rxts_q <= link.ts_from_dev;
    end
  end

  assign link.dv_to_dev = dv_q;
  assign link.udp_to_dev = udp_q;
  assign link.type_to_dev = type_q;
  assign link.mac_to_dev = mac_q;
  assign link.etype_to_dev = PTPMC_ETHERTYPE;
  assign link.ip_to_dev = ip_q;
  assign link.port_to_dev = port_q;
  assign link.ts_to_dev = ts_q;
  assign link.corr_to_dev = corr_q;
  assign o_rx_valid = rxv_q;
  assign o_rx_type = rxt_q;
  assign o_rx_ts = rxts_q;
endmodule : ptpmc_peer

//--- sim/ptpmc_link_asserts.sv
`timescale 1ns/1ps
module ptpmc_link_asserts
  import ptpmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic dv_from_dev,
  input wire logic [3:0] type_from_dev,
  input wire logic udp_from_dev,
  input wire logic [47:0] mac_from_dev,
  input wire logic [15:0] etype_from_dev,
  input wire logic [31:0] ip_from_dev,
  input wire logic [15:0] port_from_dev,
  input wire logic [63:0] ts_from_dev,
  input wire logic dv_to_dev,
  input wire logic udp_to_dev,
  input wire logic [15:0] etype_to_dev
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  wire eth_tx = dv_from_dev && !udp_from_dev;
  wire udp_tx = dv_from_dev && udp_from_dev;
  wire pd_msg = type_from_dev inside {PTPMC_PDREQ, PTPMC_PDRESP, PTPMC_PDFUP};
  tx_etype_a: assert property (
    eth_tx |-> etype_from_dev == PTPMC_ETHERTYPE)
    else $error("tx ethertype wrong");
  rx_etype_a: assert property (dv_to_dev && !udp_to_dev |->
    etype_to_dev == PTPMC_ETHERTYPE) else $error("rx ethertype wrong");
  peer_mac_a: assert property (eth_tx && pd_msg |->
    mac_from_dev == PTPMC_MAC_PDELAY) else $error("peer mac wrong");
  general_mac_a: assert property (eth_tx && !pd_msg |->
    mac_from_dev == PTPMC_MAC_GENERAL) else $error("general mac wrong");
  event_port_a: assert property (udp_tx && !type_from_dev[3] |->
    port_from_dev == PTPMC_UDP_EVENT) else $error("event port wrong");
  general_port_a: assert property (udp_tx && type_from_dev[3] |->
    port_from_dev == PTPMC_UDP_GENERAL) else $error("general port wrong");
  peer_ip_a: assert property (udp_tx && pd_msg |->
    ip_from_dev == PTPMC_IP_PDELAY) else $error("peer group wrong");
  fup_pair_a: assert property (
    dv_from_dev && type_from_dev == PTPMC_FUP |->
    $past(dv_from_dev) && $past(type_from_dev) == PTPMC_SYNC &&
    ts_from_dev == $past(ts_from_dev)) else $error("follow up unpaired");
  cover property (dv_from_dev && type_from_dev == PTPMC_SYNC);
  cover property (dv_from_dev && type_from_dev == PTPMC_FUP);
  cover property (dv_from_dev && type_from_dev == PTPMC_DRESP);
  cover property (dv_from_dev && type_from_dev == PTPMC_ANNOUNCE);
endmodule : ptpmc_link_asserts

//--- sim/ptpmc_port_tb.sv
`timescale 1ns/1ps
module ptpmc_port_tb;
  import ptpmc_pkg::*;
  localparam logic [63:0] NOW = 64'h0000_0000_0000_03e8;
  logic clk = 0, srst = 1, primary = 0, master = 1, enable = 1;
  logic one_step = 0, udp = 0, unicast = 0, rem_ok = 0, tc_en = 0, p2p = 0;
  logic fwd_v = 0, fwd_udp = 0, granted, offset_valid, rx_valid;
  logic [3:0] cnt_sel = 4'h0, fwd_type = 4'h0, rx_type;
  logic [31:0] count;
  logic [63:0] fwd_ts = '0, fwd_corr = '0, rx_ts, t_sync;
  logic signed [63:0] offset;
  logic [3:0] tl [4] = '{PTPMC_DREQ, PTPMC_FUP, PTPMC_ANNOUNCE, PTPMC_SIGNAL};
  int n_mismatch = 0, num_checks = 0, ntx = 0, cyc, base;
  always #25 clk = ~clk;
  always @(posedge clk) if (rx_valid === 1'b1) ntx <= ntx + 1;
  ptpmc_link_if link ();
  ptpmc_port #(.SYNC_PERIOD(20), .ANN_PERIOD(40)) i_ptpmc_port (
    .i_clk(clk), .i_srst(srst), .i_primary(primary), .i_master(master),
    .i_enable(enable), .i_one_step(one_step), .i_udp(udp),
    .i_unicast(unicast), .i_remote_valid(rem_ok),
    .i_remote_ip(32'hc0a8_0001), .i_now(NOW), .i_cnt_sel(cnt_sel),
    .link(link), .o_count(count), .o_granted(granted), .o_offset(offset),
    .o_offset_valid(offset_valid));
  ptpmc_peer i_ptpmc_peer (
    .i_clk(clk), .i_srst(srst), .i_tc_en(tc_en), .i_p2p(p2p),
    .i_fwd_valid(fwd_v), .i_fwd_type(fwd_type), .i_fwd_udp(fwd_udp),
    .i_fwd_ts(fwd_ts), .i_fwd_corr(fwd_corr),
    .i_residence(64'h0000_0000_0000_0007), .link(link),
    .o_rx_valid(rx_valid), .o_rx_type(rx_type), .o_rx_ts(rx_ts));
  ptpmc_link_asserts i_asserts (
    .i_clk(clk), .i_srst(srst), .dv_from_dev(link.dv_from_dev),
    .type_from_dev(link.type_from_dev), .udp_from_dev(link.udp_from_dev),
    .mac_from_dev(link.mac_from_dev), .etype_from_dev(link.etype_from_dev),
    .ip_from_dev(link.ip_from_dev), .port_from_dev(link.port_from_dev),
    .ts_from_dev(link.ts_from_dev), .dv_to_dev(link.dv_to_dev),
    .udp_to_dev(link.udp_to_dev), .etype_to_dev(link.etype_to_dev));
  task automatic check(input logic [63:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic fwd(input logic [3:0] t, input logic [63:0] ts, corr);
    @(negedge clk);
    fwd_v = 1;
    fwd_type = t;
    fwd_ts = ts;
    fwd_corr = corr;
    @(negedge clk);
    fwd_v = 0;
  endtask : fwd
  // Peer output is registered, so the copy lands one cycle after the wire
  task automatic wait_rx(input logic [3:0] t, output int c);
    for (c = 0; c < 100; c++) begin
      @(posedge clk);
      #1;
      if (rx_valid === 1'b1 && rx_type === t) break;
    end
  endtask : wait_rx
  task automatic tc(input logic [3:0] t, input logic [63:0] exp,
                    input bit drop);
    logic seen = 0;
    logic [63:0] c = '0;
    fwd(t, '0, 64'h0000_0000_0000_0005);
    repeat (2) begin
      if (link.dv_to_dev === 1'b1) begin
        seen = 1;
        c = link.corr_to_dev;
      end
      @(negedge clk);
    end
    check(seen, !drop, "forwarding");
    if (!drop) check(c, exp, "correction");
  endtask : tc
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    #150000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (10) @(negedge clk);
    srst = 0;
    for (int i = 0; i < 4; i++) repeat (i + 1) fwd(tl[i], '0, '0);
    for (int i = 0; i < 4; i++) begin
      cnt_sel = tl[i];
      repeat (3) @(negedge clk);
      check(count, i + 1, "type count");
    end
    check(ntx, 0, "secondary sent");
    primary = 1;
    wait_rx(PTPMC_SYNC, cyc);
    t_sync = rx_ts;
    check(t_sync, NOW, "sync time");
    @(posedge clk);
    #1;
    check(rx_valid === 1'b1 && rx_type === PTPMC_FUP, 1, "follow up");
    check(rx_ts, t_sync, "follow up time");
    wait_rx(PTPMC_SYNC, cyc);
    check(cyc, 8'h12, "sync period");
    wait_rx(PTPMC_ANNOUNCE, cyc);
    check(cyc < 4, 1, "announce");
    @(negedge clk);
    one_step = 1;
    wait_rx(PTPMC_SYNC, cyc);
    check(rx_ts, NOW, "one step time");
    @(posedge clk);
    #1;
    check(rx_valid, 0, "extra follow up");
    fwd(PTPMC_DREQ, '0, '0);
    wait_rx(PTPMC_DRESP, cyc);
    check(cyc < 4, 1, "delay reply");
    check(rx_ts, NOW, "reply time");
    tc_en = 1;
    tc(PTPMC_SYNC, 64'h0000_0000_0000_000c, 0);
    tc(PTPMC_DREQ, 64'h0000_0000_0000_000c, 0);
    p2p = 1;
    tc(PTPMC_FUP, 64'h0000_0000_0000_000c, 0);
    tc(PTPMC_DREQ, 64'h0000_0000_0000_0005, 0);
    tc(PTPMC_PDREQ, '0, 1);
    tc(PTPMC_PDRESP, '0, 1);
    tc_en = 0;
    p2p = 0;
    unicast = 1;
    udp = 1;
    fwd_udp = 1;
    repeat (2) @(negedge clk);
    base = ntx;
    repeat (60) @(negedge clk);
    check(ntx - base, 0, "unicast no remote");
    rem_ok = 1;
    udp = 0;
    repeat (2) @(negedge clk);
    base = ntx;
    repeat (60) @(negedge clk);
    check(ntx - base, 0, "unicast over ethernet");
    udp = 1;
    master = 0;
    wait_rx(PTPMC_SIGNAL, cyc);
    check(cyc < 100, 1, "grant request");
    check(granted, 0, "early grant");
    fwd(PTPMC_SIGNAL, '0, '0);
    @(negedge clk);
    check(granted, 1, "grant");
    fwd(PTPMC_SYNC, 64'h0000_0000_0000_0064, '0);
    fwd(PTPMC_FUP, 64'h0000_0000_0000_0064, '0);
    wait_rx(PTPMC_DREQ, cyc);
    check(cyc < 100, 1, "delay request");
    fwd(PTPMC_DRESP, 64'h0000_0000_0000_0410, '0);
    repeat (5) if (offset_valid !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    check(offset_valid, 1, "offset strobe");
    check(offset, 64'h0000_0000_0000_01ae, "offset value");
    complete_run();
  end
endmodule : ptpmc_port_tb
